// ### rtl/plb_logic_block.v
// Logic block: 36 interconnect inputs, 16 macrocells, 32 feedbacks.
// Assumes all inputs, including the clock source pins, are synchronous to i_clk.
// Every configuration bit is a static input port, held stable in operation.
`timescale 1ns/100ps
`default_nettype none
`include "plb_regs.vh"

module plb_logic_block (
    input wire i_clk,
    input wire i_rst,
    input wire [`PLB_N_IN-1:0] i_interconnect_array,
    input wire i_global_clock_zero,
    input wire i_global_clock_one,
    input wire i_global_clock_two,
    input wire i_global_clock_three,
    input wire i_global_tristate_pin,
    input wire i_gts_en,
    input wire [2:0] i_gclk_use_mc,
    input wire [11:0] i_gclk_mc_idx,
    input wire [`PLB_N_MC*`PLB_N_PAL*`PLB_N_IN-1:0] i_pal_true,
    input wire [`PLB_N_MC*`PLB_N_PAL*`PLB_N_IN-1:0] i_pal_comp,
    input wire [`PLB_N_PLA*`PLB_N_IN-1:0] i_pla_true,
    input wire [`PLB_N_PLA*`PLB_N_IN-1:0] i_pla_comp,
    input wire [`PLB_N_MC*`PLB_N_PLA-1:0] i_pla_or,
    input wire [`PLB_N_CT*`PLB_N_IN-1:0] i_ct_true,
    input wire [`PLB_N_CT*`PLB_N_IN-1:0] i_ct_comp,
    input wire [`PLB_N_CT-1:0] i_ct_sum,
    input wire [`PLB_N_MC*2-1:0] i_mc_mode,
    input wire [`PLB_N_MC*3-1:0] i_mc_clk_sel,
    input wire [`PLB_N_MC-1:0] i_mc_clk_fall,
    input wire [`PLB_N_MC-1:0] i_mc_pr_en,
    input wire [`PLB_N_MC*3-1:0] i_mc_oe_sel,
    input wire [`PLB_N_MC-1:0] i_pin,
    output wire [`PLB_N_MC-1:0] o_pin,
    output wire [`PLB_N_MC-1:0] o_pin_oe_n,
    output wire [`PLB_N_FB-1:0] o_interconnect_feedback,
    output wire [`PLB_N_CT-1:0] o_ctrl_term
);

    // ======================================================================
    // Declarations
    wire [`PLB_N_MC*`PLB_N_PAL-1:0] pal_term;
    wire [`PLB_N_PLA-1:0] pla_term;
    wire [`PLB_N_CT-1:0] ctrl_term;
    wire ctrl_term_zero;
    wire ctrl_term_one;
    wire ctrl_term_two;
    wire ctrl_term_three;
    wire ctrl_term_four;
    wire ctrl_term_five;
    wire [3:0] gclk_src;
    wire [`PLB_N_SRC-1:0] clk_src;
    wire [`PLB_N_SRC-1:0] rise_ev;
    wire [`PLB_N_SRC-1:0] fall_ev;
    wire [`PLB_N_MC-1:0] mc_res;
    wire gts_off;

    // ======================================================================
    // Private product terms, five per macrocell, all over the 36 inputs
    genvar k;
    generate
        for (k = 0; k < `PLB_N_MC*`PLB_N_PAL; k = k + 1) begin : g_pal
            plb_term u_term (
                .i_sig(i_interconnect_array),
                .i_use_true(i_pal_true[k*`PLB_N_IN +: `PLB_N_IN]),
                .i_use_comp(i_pal_comp[k*`PLB_N_IN +: `PLB_N_IN]),
                .i_is_sum(1'b0),
                .o_term(pal_term[k])
            );
        end
    endgenerate

    // ======================================================================
    // Shared product term pool
    genvar p;
    generate
        for (p = 0; p < `PLB_N_PLA; p = p + 1) begin : g_pla
            plb_term u_term (
                .i_sig(i_interconnect_array),
                .i_use_true(i_pla_true[p*`PLB_N_IN +: `PLB_N_IN]),
                .i_use_comp(i_pla_comp[p*`PLB_N_IN +: `PLB_N_IN]),
                .i_is_sum(1'b0),
                .o_term(pla_term[p])
            );
        end
    endgenerate

    // ======================================================================
    // Control terms, each its own choice of product or sum
    genvar c;
    generate
        for (c = 0; c < `PLB_N_CT; c = c + 1) begin : g_ct
            plb_term u_term (
                .i_sig(i_interconnect_array),
                .i_use_true(i_ct_true[c*`PLB_N_IN +: `PLB_N_IN]),
                .i_use_comp(i_ct_comp[c*`PLB_N_IN +: `PLB_N_IN]),
                .i_is_sum(i_ct_sum[c]),
                .o_term(ctrl_term[c])
            );
        end
    endgenerate

    assign ctrl_term_zero = ctrl_term[0];
    assign ctrl_term_one = ctrl_term[1];
    assign ctrl_term_two = ctrl_term[2];
    assign ctrl_term_three = ctrl_term[3];
    assign ctrl_term_four = ctrl_term[4];
    assign ctrl_term_five = ctrl_term[5];
    assign o_ctrl_term = ctrl_term;

    // ======================================================================
    // Global clock sources
    // Clock zero has no internal path; the others may take a macrocell result.
    assign gclk_src[0] = i_global_clock_zero;
    assign gclk_src[1] = i_gclk_use_mc[0] ? mc_res[i_gclk_mc_idx[3:0]]
                                          : i_global_clock_one;
    assign gclk_src[2] = i_gclk_use_mc[1] ? mc_res[i_gclk_mc_idx[7:4]]
                                          : i_global_clock_two;
    assign gclk_src[3] = i_gclk_use_mc[2] ? mc_res[i_gclk_mc_idx[11:8]]
                                          : i_global_clock_three;

    // Six sources: four global networks, then control terms two and three.
    assign clk_src = {ctrl_term_three, ctrl_term_two, gclk_src};

    // ======================================================================
    // Edge detection of every clock source
    // Sources are sampled, so an edge is acted on at the system clock edge
    // that first sees the new level; pulses shorter than a cycle are lost.
    genvar e;
    generate
        for (e = 0; e < `PLB_N_SRC; e = e + 1) begin : g_edge
            plb_edge u_edge (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_src(clk_src[e]),
                .o_rise(rise_ev[e]),
                .o_fall(fall_ev[e])
            );
        end
    endgenerate

    // ======================================================================
    // Global tristate
    assign gts_off = i_gts_en & ~i_global_tristate_pin;

    // ======================================================================
    // Macrocells
    genvar m;
    generate
        for (m = 0; m < `PLB_N_MC; m = m + 1) begin : g_mc
            wire [1:0] mode;
            wire [2:0] csel;
            wire [2:0] osel;
            wire pal_sum;
            wire pla_sum;
            wire sum;
            wire is_reg;
            reg clk_ev;
            reg oe_on;
            reg mc_d;
            reg mc_q;

            assign mode = i_mc_mode[m*2 +: 2];
            assign csel = i_mc_clk_sel[m*3 +: 3];
            assign osel = i_mc_oe_sel[m*3 +: 3];

            // Five private terms plus any of the 32 shared ones: up to 37.
            assign pal_sum = |pal_term[m*`PLB_N_PAL +: `PLB_N_PAL];
            assign pla_sum = |(pla_term & i_pla_or[m*`PLB_N_PLA +: `PLB_N_PLA]);
            assign sum = pal_sum | pla_sum;

            // The edge choice applies to global clocks only; control term
            // clocks act on their rising edge, inversion being done in the term.
            always @* begin
                clk_ev = 1'b0;
                case (csel)
                    3'h0, 3'h1, 3'h2, 3'h3: begin
                        clk_ev = i_mc_clk_fall[m] ? fall_ev[csel[1:0]]
                                                  : rise_ev[csel[1:0]];
                    end
                    `PLB_CLK_CT2: begin
                        clk_ev = rise_ev[4];
                    end
                    `PLB_CLK_CT3: begin
                        clk_ev = rise_ev[5];
                    end
                    default: begin
                        clk_ev = 1'b0;
                    end
                endcase
            end

            // Preset and reset act ahead of any clock edge; reset wins a tie.
            always @* begin
                mc_d = mc_q;
                if (i_mc_pr_en[m] && ctrl_term_one) begin
                    mc_d = 1'b0;
                end else if (i_mc_pr_en[m] && ctrl_term_zero) begin
                    mc_d = 1'b1;
                end else if (clk_ev) begin
                    case (mode)
                        `PLB_MODE_D: begin
                            mc_d = sum;
                        end
                        `PLB_MODE_T: begin
                            mc_d = mc_q ^ sum;
                        end
                        default: begin
                            mc_d = mc_q;
                        end
                    endcase
                end
            end

            always @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    mc_q <= `PLB_MC_RST_VAL;
                end else begin
                    mc_q <= mc_d;
                end
            end

            assign is_reg = (mode == `PLB_MODE_D) || (mode == `PLB_MODE_T);
            assign mc_res[m] = is_reg ? mc_q : sum;

            always @* begin
                oe_on = 1'b0;
                case (osel)
                    `PLB_OE_CT2: begin
                        oe_on = ctrl_term_two;
                    end
                    `PLB_OE_CT3: begin
                        oe_on = ctrl_term_three;
                    end
                    `PLB_OE_CT4: begin
                        oe_on = ctrl_term_four;
                    end
                    `PLB_OE_CT5: begin
                        oe_on = ctrl_term_five;
                    end
                    `PLB_OE_ON: begin
                        oe_on = 1'b1;
                    end
                    default: begin
                        oe_on = 1'b0;
                    end
                endcase
            end

            assign o_pin[m] = mc_res[m];
            assign o_pin_oe_n[m] = ~(oe_on & ~gts_off);
        end
    endgenerate

    // ======================================================================
    // Feedback to the interconnect
    // Low half is the buried result, high half the pin level, so a pin used
    // as input and its macrocell stay usable at the same time.
    assign o_interconnect_feedback = {i_pin, mc_res};

endmodule // plb_logic_block

`default_nettype wire

// ### rtl/plb_regs.vh
// Constants of the programmable logic block: sizes, configuration encodings and reset values.
// Assumes one system clock. Every configuration field arrives as a plain input port.
//
// How it works
// - Each macrocell runs as D register, T register or plain combinational sum.
// - Register clock comes from one of four global clocks or control terms two, three.
// - Global clock zero is pin only; clocks one to three take pin or macrocell.
// - Each global clock may act on its rising or its falling edge, per macrocell.
// - Control terms two and three as clocks are product or sum over 36 inputs.
// - Six control terms per block, each configured as AND or OR of inputs.
// - Control terms zero, one preset and reset registers; each macrocell may disable them.
// - Reset clears every macrocell register to zero.
// - Output enable picks control term two to five, always on or always off.
// - Enabled global tristate pin held low floats every output pin.
// - Each macrocell returns its result and its pin level to the interconnect.
// - An input pin keeps its buffer off; pin and buried result feed back separately.
// - Each macrocell has five private product terms through a fixed OR.
// - Thirty-two shared product terms reach any macrocell through a programmable OR.
// - One macrocell output can combine up to 37 product terms.
// - Block takes 36 interconnect inputs, has 16 macrocells, returns 32 feedbacks.
`ifndef PLB_REGS_VH
`define PLB_REGS_VH

// ==========================================================================
// Sizes
`define PLB_N_IN 36
`define PLB_N_MC 16
`define PLB_N_PAL 5
`define PLB_N_PLA 32
`define PLB_N_CT 6
`define PLB_N_FB 32
`define PLB_N_SRC 6

// ==========================================================================
// Macrocell modes
`define PLB_MODE_COMB 2'h0
`define PLB_MODE_D 2'h1
`define PLB_MODE_T 2'h2

// ==========================================================================
// Clock source codes: global clocks 0 to 3, then control terms two and three
`define PLB_CLK_CT2 3'h4
`define PLB_CLK_CT3 3'h5

// ==========================================================================
// Output enable codes: control terms two to five, then fixed on and off
`define PLB_OE_CT2 3'h0
`define PLB_OE_CT3 3'h1
`define PLB_OE_CT4 3'h2
`define PLB_OE_CT5 3'h3
`define PLB_OE_ON 3'h4
`define PLB_OE_OFF 3'h5

// ==========================================================================
// Reset values
`define PLB_MC_RST_VAL 1'b0
`define PLB_EDGE_RST_VAL 1'b0

`endif

// ### rtl/plb_term.v
// One programmable term: AND or OR over chosen true and complement literals.
// Assumes purely combinational use; an unprogrammed product term gives zero.
`timescale 1ns/100ps
`default_nettype none
`include "plb_regs.vh"

module plb_term (
    input wire [`PLB_N_IN-1:0] i_sig,
    input wire [`PLB_N_IN-1:0] i_use_true,
    input wire [`PLB_N_IN-1:0] i_use_comp,
    input wire i_is_sum,
    output wire o_term
);

    wire [`PLB_N_IN-1:0] and_ok;
    wire [`PLB_N_IN-1:0] or_hit;
    wire any_lit;

    // An empty product would read as one and swamp every OR it feeds.
    assign and_ok = (~i_use_true | i_sig) & (~i_use_comp | ~i_sig);
    assign or_hit = (i_use_true & i_sig) | (i_use_comp & ~i_sig);
    assign any_lit = |(i_use_true | i_use_comp);
    assign o_term = i_is_sum ? (|or_hit) : (any_lit & (&and_ok));

endmodule // plb_term

`default_nettype wire

// ### rtl/plb_edge.v
// Edge detector for one clock source sampled on the system clock.
// Assumes the source is synchronous to i_clk, so no synchroniser is needed.
`timescale 1ns/100ps
`default_nettype none
`include "plb_regs.vh"

module plb_edge (
    input wire i_clk,
    input wire i_rst,
    input wire i_src,
    output wire o_rise,
    output wire o_fall
);

    reg prev_q;

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            prev_q <= `PLB_EDGE_RST_VAL;
        end else begin
            prev_q <= i_src;
        end
    end

    assign o_rise = i_src & ~prev_q;
    assign o_fall = ~i_src & prev_q;

endmodule // plb_edge

`default_nettype wire

// ### testbench/plb_logic_block_asserts.sv
// Checker for the logic block: relations at the ports for macrocell zero and all pins.
// Assumes it is bound to plb_logic_block and that configuration holds between tests.
`timescale 1ns/100ps
`default_nettype none
module plb_logic_block_asserts (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_global_clock_zero,
    input wire logic i_global_tristate_pin,
    input wire logic i_gts_en,
    input wire logic [31:0] i_mc_mode,
    input wire logic [47:0] i_mc_clk_sel,
    input wire logic [15:0] i_mc_clk_fall,
    input wire logic [15:0] i_mc_pr_en,
    input wire logic [47:0] i_mc_oe_sel,
    input wire logic [15:0] i_pin,
    input wire logic [15:0] o_pin,
    input wire logic [15:0] o_pin_oe_n,
    input wire logic [31:0] o_interconnect_feedback,
    input wire logic [5:0] o_ctrl_term
);
    // ======================================================================
    // Helpers and properties
    wire logic reg0 = (i_mc_mode[1:0] == 2'h1) || (i_mc_mode[1:0] == 2'h2);
    wire logic flt = i_gts_en && !i_global_tristate_pin;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_clear;
        i_mc_pr_en[0] && o_ctrl_term[1] && reg0;
    endsequence
    sequence s_set;
        i_mc_pr_en[0] && o_ctrl_term[0] && !o_ctrl_term[1] && reg0;
    endsequence
    a_tristate_floats_all: assert property (flt |-> &o_pin_oe_n)
        else $error("Global tristate left a pin driven.");
    a_pin_feedback_path: assert property (o_interconnect_feedback[31:16] == i_pin)
        else $error("Pin feedback differs from pin.");
    a_mc_feedback_path: assert property (o_interconnect_feedback[15:0] == o_pin)
        else $error("Macrocell feedback differs from result.");
    a_oe_always_on: assert property (i_mc_oe_sel[2:0] == 3'h4 && !flt |-> !o_pin_oe_n[0])
        else $error("Always-on buffer is off.");
    a_oe_always_off: assert property (i_mc_oe_sel[2:0] == 3'h5 |-> o_pin_oe_n[0])
        else $error("Always-off buffer is on.");
    a_oe_term_two: assert property (i_mc_oe_sel[2:0] == 3'h0 && !flt |-> o_pin_oe_n[0] == !o_ctrl_term[2])
        else $error("Buffer does not follow control term two.");
    a_hold_no_edge: assert property (reg0 && i_mc_clk_sel[2:0] == 3'h0 && !i_mc_pr_en[0]
        && !$past(i_rst) && !(i_mc_clk_fall[0] ? $fell(i_global_clock_zero)
        : $rose(i_global_clock_zero)) |=> !$stable(i_mc_mode[1:0]) || $stable(o_pin[0]))
        else $error("Register moved without its clock edge.");
    a_reset_term_wins: assert property (s_clear |=> !$stable(i_mc_mode[1:0]) || !o_pin[0])
        else $error("Reset term did not clear.");
    a_preset_term_sets: assert property (s_set |=> !$stable(i_mc_mode[1:0]) || o_pin[0])
        else $error("Preset term did not set.");
    a_reset_clears_reg: assert property ($fell(i_rst) && reg0 |-> !o_pin[0])
        else $error("Register not zero after reset.");
endmodule // plb_logic_block_asserts

bind plb_logic_block plb_logic_block_asserts u_chk (.i_clk(i_clk), .i_rst(i_rst),
    .i_global_clock_zero(i_global_clock_zero), .i_global_tristate_pin(i_global_tristate_pin),
    .i_gts_en(i_gts_en), .i_mc_mode(i_mc_mode), .i_mc_clk_sel(i_mc_clk_sel),
    .i_mc_clk_fall(i_mc_clk_fall), .i_mc_pr_en(i_mc_pr_en), .i_mc_oe_sel(i_mc_oe_sel),
    .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n),
    .o_interconnect_feedback(o_interconnect_feedback), .o_ctrl_term(o_ctrl_term));
`default_nettype wire

// ### testbench/plb_board_model.sv
// Board model: global clock pins, tester tristate pin and the level on each I/O wire.
// Assumes one system clock; a clock line moves only when the bench requests a toggle.
`timescale 1ns/100ps
`default_nettype none
module plb_board_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [3:0] i_tgl,
    input wire logic i_float,
    input wire logic [15:0] i_bd_en,
    input wire logic [15:0] i_bd_val,
    input wire logic [15:0] i_pin_out,
    input wire logic [15:0] i_pin_oe_n,
    output logic [3:0] o_gclk,
    output logic o_tristate_pin,
    output logic [15:0] o_pin_wire
);
    logic [15:0] last_q;
    // Clock lines stand still between toggles, parked low in reset.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_gclk <= 4'h0;
            last_q <= 16'h0;
        end else begin
            o_gclk <= o_gclk ^ i_tgl;
            last_q <= o_pin_wire;
        end
    end
    // The tester pulls this pin low to float the outputs.
    assign o_tristate_pin = !i_float;
    // No pull resistor, so a wire nobody drives shows the inverse of its last level.
    assign o_pin_wire = (~i_pin_oe_n & i_pin_out) | (i_pin_oe_n & i_bd_en & i_bd_val)
        | (i_pin_oe_n & ~i_bd_en & ~last_q);
endmodule // plb_board_model
`default_nettype wire

// ### testbench/plb_logic_block_tb.sv
// Testbench for the logic block, exercising macrocell zero and one through their ports.
// Assumes the board model for clocks and wires; clock events land two edges after a toggle.
`timescale 1ns/100ps
`default_nettype none
module plb_logic_block_tb;
    logic i_clk, i_rst, gts_en, fl;
    logic [35:0] ia;
    logic [3:0] tgl;
    logic [2:0] use_mc;
    logic [11:0] idx;
    logic [2879:0] pal_t, pal_c;
    logic [1151:0] pla_t, pla_c;
    logic [511:0] pla_or;
    logic [215:0] ct_t, ct_c;
    logic [5:0] ct_sum;
    logic [31:0] mode;
    logic [47:0] csel, oesel;
    logic [15:0] cfall, pren, bd_en, bd_val;
    wire logic [3:0] gclk;
    wire logic gts_n;
    wire logic [15:0] pin_w, o_pin, oe_n;
    wire logic [31:0] fb;
    wire logic [5:0] ctv;
    integer fails, total_checks, c;
    localparam int PIN = 0, OEN = 16, FBK = 32, CTV = 64;
    wire logic [69:0] obs = {ctv, fb, oe_n, o_pin};
    plb_board_model u_board (.i_clk(i_clk), .i_rst(i_rst), .i_tgl(tgl), .i_float(fl),
        .i_bd_en(bd_en), .i_bd_val(bd_val), .i_pin_out(o_pin), .i_pin_oe_n(oe_n),
        .o_gclk(gclk), .o_tristate_pin(gts_n), .o_pin_wire(pin_w));
    plb_logic_block dut (.i_clk(i_clk), .i_rst(i_rst), .i_interconnect_array(ia),
        .i_global_clock_zero(gclk[0]), .i_global_clock_one(gclk[1]),
        .i_global_clock_two(gclk[2]), .i_global_clock_three(gclk[3]),
        .i_global_tristate_pin(gts_n), .i_gts_en(gts_en), .i_gclk_use_mc(use_mc),
        .i_gclk_mc_idx(idx), .i_pal_true(pal_t), .i_pal_comp(pal_c), .i_pla_true(pla_t),
        .i_pla_comp(pla_c), .i_pla_or(pla_or), .i_ct_true(ct_t), .i_ct_comp(ct_c),
        .i_ct_sum(ct_sum), .i_mc_mode(mode), .i_mc_clk_sel(csel), .i_mc_clk_fall(cfall),
        .i_mc_pr_en(pren), .i_mc_oe_sel(oesel), .i_pin(pin_w), .o_pin(o_pin),
        .o_pin_oe_n(oe_n), .o_interconnect_feedback(fb), .o_ctrl_term(ctv));
    always #5 i_clk = ~i_clk;
    // ======================================================================
    // Shared tasks
    // The bit is read here after the delay, so updates launched by this edge are seen.
    task automatic chk(input int idx, input logic exp);
        #1;
        total_checks = total_checks + 1;
        if (obs[idx] !== exp) begin
            fails = fails + 1;
            $display("[FAIL] %0t: bit %0d got %b expected %b", $time, idx, obs[idx], exp);
        end
    endtask
    task automatic gt(input logic [3:0] m);
        @(posedge i_clk) tgl <= m;
        @(posedge i_clk) tgl <= 4'h0;
        repeat (2) @(posedge i_clk);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ======================================================================
    // Scenarios
    task automatic t_dreg;
        chk(PIN + 0, 1'b0);
        @(posedge i_clk) ia[0] <= 1'b1;
        gt(4'h1);
        chk(PIN + 0, 1'b1);
        @(posedge i_clk) ia[0] <= 1'b0;
        gt(4'h1);
        chk(PIN + 0, 1'b1);
        gt(4'h1);
        chk(PIN + 0, 1'b0);
        @(posedge i_clk) begin
            csel[2:0] <= 3'h1;
            cfall[0] <= 1'b1;
            ia[0] <= 1'b1;
        end
        gt(4'h2);
        chk(PIN + 0, 1'b0);
        gt(4'h2);
        chk(PIN + 0, 1'b1);
        $display("dreg done");
    endtask
    task automatic t_treg;
        @(posedge i_clk) begin
            mode[1:0] <= 2'h2;
            csel[2:0] <= 3'h2;
            cfall[0] <= 1'b0;
        end
        gt(4'h4);
        chk(PIN + 0, 1'b0);
        gt(4'h4);
        gt(4'h4);
        chk(PIN + 0, 1'b1);
        @(posedge i_clk) ia[0] <= 1'b0;
        gt(4'h4);
        gt(4'h4);
        chk(PIN + 0, 1'b1);
        $display("treg done");
    endtask
    task automatic t_comb;
        @(posedge i_clk) begin
            mode[1:0] <= 2'h0;
            pla_t[113] <= 1'b1;
            pla_or[31:0] <= 32'hFFFFFFFF;
            pla_or[35] <= 1'b1;
            pal_t[150] <= 1'b1;
            ia <= 36'h000000020;
        end
        chk(PIN + 0, 1'b1);
        chk(PIN + 1, 1'b1);
        @(posedge i_clk) ia <= 36'h000000040;
        chk(PIN + 0, 1'b1);
        chk(PIN + 1, 1'b0);
        $display("comb done");
    endtask
    // The register leaves the previous test at one, so reset is shown first.
    task automatic t_ctrl;
        @(posedge i_clk) begin
            mode[1:0] <= 2'h1;
            csel[2:0] <= 3'h7;
            pren[0] <= 1'b1;
            ia <= 36'h000000004;
        end
        chk(CTV + 1, 1'b1);
        @(posedge i_clk);
        chk(PIN + 0, 1'b0);
        @(posedge i_clk) ia <= 36'h000000002;
        chk(CTV + 0, 1'b1);
        @(posedge i_clk);
        chk(PIN + 0, 1'b1);
        @(posedge i_clk) ia <= 36'h00000000A;
        @(posedge i_clk);
        chk(PIN + 0, 1'b0);
        @(posedge i_clk) ia <= 36'h000000002;
        @(posedge i_clk) begin
            pren[0] <= 1'b0;
            ia <= 36'h000000004;
        end
        @(posedge i_clk);
        chk(PIN + 0, 1'b1);
        $display("ctrl done");
    endtask
    task automatic t_ctclk;
        @(posedge i_clk) begin
            csel[2:0] <= 3'h4;
            ia <= 36'h000000010;
        end
        @(posedge i_clk);
        chk(PIN + 0, 1'b0);
        @(posedge i_clk) ia <= 36'h000000000;
        @(posedge i_clk) ia <= 36'h000000011;
        @(posedge i_clk);
        chk(PIN + 0, 1'b1);
        $display("ctclk done");
    endtask
    task automatic t_oe;
        @(posedge i_clk) begin
            csel[2:0] <= 3'h7;
            oesel[5:3] <= 3'h4;
            ct_t[112] <= 1'b1;
            ct_t[148] <= 1'b1;
            ct_t[184] <= 1'b1;
        end
        for (c = 0; c < 6; c = c + 1) begin
            @(posedge i_clk) oesel[2:0] <= c[2:0];
            chk(OEN + 0, (c == 5) ? 1'b1 : 1'b0);
        end
        @(posedge i_clk) begin
            ia <= 36'h000000000;
            oesel[2:0] <= 3'h3;
        end
        chk(OEN + 0, 1'b1);
        @(posedge i_clk) begin
            oesel[2:0] <= 3'h5;
            bd_en[0] <= 1'b1;
        end
        chk(FBK + 16, 1'b0);
        chk(FBK + 0, 1'b1);
        @(posedge i_clk) bd_val[0] <= 1'b1;
        chk(FBK + 16, 1'b1);
        @(posedge i_clk) begin
            oesel[2:0] <= 3'h4;
            bd_en[0] <= 1'b0;
        end
        chk(OEN + 0, 1'b0);
        chk(FBK + 16, 1'b1);
        @(posedge i_clk) begin
            gts_en <= 1'b1;
            fl <= 1'b1;
        end
        chk(OEN + 0, 1'b1);
        chk(OEN + 1, 1'b1);
        @(posedge i_clk) gts_en <= 1'b0;
        chk(OEN + 0, 1'b0);
        @(posedge i_clk) fl <= 1'b0;
        $display("oe done");
    endtask
    // Shared term three leaves macrocell zero, so its sum is low while the
    // internal clock rises, and a wrongly used pin clock would clear it.
    task automatic t_gint;
        @(posedge i_clk) begin
            use_mc[0] <= 1'b1;
            idx[3:0] <= 4'h1;
            csel[2:0] <= 3'h1;
            cfall[0] <= 1'b0;
            pla_or[3] <= 1'b0;
        end
        gt(4'h2);
        chk(PIN + 0, 1'b1);
        @(posedge i_clk) ia <= 36'h000000020;
        @(posedge i_clk);
        chk(PIN + 0, 1'b0);
        $display("gint done");
    endtask
    initial begin
        {i_clk, gts_en, fl, ia, tgl, use_mc, idx, pal_c, pla_t, pla_c, pla_or} = '0;
        {ct_c, ct_sum, csel, oesel, cfall, pren, bd_en, bd_val, fails, total_checks} = '0;
        pal_t = '0;
        pal_t[0] = 1'b1;
        ct_t = '0;
        ct_t[1] = 1'b1;
        ct_t[38] = 1'b1;
        ct_t[39] = 1'b1;
        ct_t[76] = 1'b1;
        ct_sum[1] = 1'b1;
        mode = 32'h00000001;
        i_rst = 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        t_dreg();
        t_treg();
        t_comb();
        t_ctrl();
        t_ctclk();
        t_oe();
        t_gint();
        tally_and_finish();
    end
endmodule // plb_logic_block_tb
`default_nettype wire
